// File: src/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

  // Register byte addresses on the Avalon-MM slave
  localparam logic [4:0] ADDR_ALARM_WEEKDAY_DIGIT_HOURS = 5'h00;
  localparam logic [4:0] ADDR_ALARM_MIN_SEC    = 5'h04;
  localparam logic [4:0] ADDR_ALARM_CONFIG     = 5'h08;
  localparam logic [4:0] ADDR_CLOCK_TRIM       = 5'h0C;
  localparam logic [4:0] ADDR_STATUS           = 5'h10;

  // Implemented bits of the two alarm value registers
  localparam logic [15:0] WEEKDAY_DIGIT_HOURS_MASK = 16'h073F;
  localparam logic [15:0] MIN_SEC_MASK    = 16'h7F7F;

  // Field positions of the alarm weekday/hours register
  localparam int WEEKDAY_DIGIT_LSB  = 8;
  localparam int WEEKDAY_DIGIT_MSB  = 10;
  localparam int HOUR_LSB  = 0;
  localparam int HOUR_MSB  = 5;
  // Field positions of the alarm minutes/seconds register
  localparam int MIN_LSB   = 8;
  localparam int MIN_MSB   = 14;
  localparam int SEC_LSB   = 0;
  localparam int SEC_MSB   = 6;
  localparam int SEC_ONES_MSB = 3;

  // Field positions of the alarm configuration register
  localparam int CFG_ON_BIT    = 15;
  localparam int CFG_CHIME_BIT = 14;
  localparam int CFG_MASK_LSB  = 10;
  localparam int CFG_MASK_MSB  = 13;
  localparam int CFG_RPT_LSB   = 0;
  localparam int CFG_RPT_MSB   = 7;

  // Field positions of the clock configuration / trim register
  localparam int TRIM_LSB        = 0;
  localparam int TRIM_MSB        = 7;
  localparam int SYNC_FLAG_BIT   = 12;
  localparam int WR_UNLOCK_BIT   = 13;

  // Field positions of the status register
  localparam int STAT_PULSE_BIT  = 0;
  localparam int STAT_ADJ_BIT    = 1;
  localparam int STAT_MATCH_BIT  = 2;

  // Reset values and the chime wrap value of the repeat count
  localparam logic [7:0]  REPEAT_RESET = 8'h00;
  localparam logic [7:0]  REPEAT_WRAP  = 8'hFF;
  localparam logic [7:0]  TRIM_RESET   = 8'h00;
  localparam logic [15:0] VALUE_RESET  = 16'h0000;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  // Shift applied to the trim magnitude: four pulses per unit of trim
  localparam int TRIM_SHIFT = 2;

  // Alarm interval codes
  typedef enum logic [3:0] {
    MASK_HALF_SEC = 4'h0,
    MASK_SEC      = 4'h1,
    MASK_TEN_SEC  = 4'h2,
    MASK_MINUTE   = 4'h3,
    MASK_TEN_MIN  = 4'h4,
    MASK_HOUR     = 4'h5,
    MASK_DAY      = 4'h6,
    MASK_WEEK     = 4'h7,
    MASK_MONTH    = 4'h8,
    MASK_YEAR     = 4'h9
  } interval_t;

  // Running clock digits, all BCD
  typedef struct packed {
    logic [4:0] month;   // tens 4, ones 3:0
    logic [5:0] day;     // tens 5:4, ones 3:0
    logic [2:0] weekday_digit;
    logic [5:0] hour;    // tens 5:4, ones 3:0
    logic [6:0] minute;  // tens 6:4, ones 3:0
    logic [6:0] second;  // tens 6:4, ones 3:0
  } clock_time_t;

  // Alarm month/day value, same BCD layout as the clock
  typedef struct packed {
    logic [4:0] month;
    logic [5:0] day;
  } month_day_t;

endpackage : rtc_alarm_pkg

// File: src/rtc_alarm_cal.sv
`timescale 1ns/1ps
module rtc_alarm_cal (
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Avalon-MM slave
  input  wire logic [4:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  // Running clock
  input  wire rtc_alarm_pkg::clock_time_t now_time,
  input  wire rtc_alarm_pkg::month_day_t  alarm_month_day,
  input  wire logic                       half_sec_tick,
  input  wire logic                       time_update,
  input  wire logic                       minute_tick,
  input  wire logic                       rollover_pending_flag,
  // Alarm outputs
  output logic                            alarm_irq,
  output logic                            alarm_pulse,
  // Trim pulses towards the clock counter
  output logic                            trim_add_pulse,
  output logic                            trim_sub_pulse
);

  // Stored alarm value registers and configuration
  logic [15:0]                  alarm_weekday_hours;
  logic [15:0]                  alarm_minutes_seconds;
  logic                         alarm_on;
  logic                         chime;
  logic [3:0]                   alarm_interval_select;
  logic [7:0]                   repeat_count;
  logic [7:0]                   trim;
  logic                         clock_write_unlock;

  // Internal state
  logic                         bus_req;
  logic                         bus_take;
  logic                         wr_take;
  logic                         prev_match;
  logic                         digits_match;
  logic                         alarm_event;
  logic [9:0]                   adjust_left;
  logic                         adjust_down;
  logic [31:0]                  next_readdata;
  logic [7:0]                   abs_trim;

  // Byte-lane merge: keeps old bits where the lane is not enabled
  function automatic logic [15:0] merge_low(input logic [15:0] old_val,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  be);
    logic [15:0] res;
    res = old_val;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge_low

  // Whether the selected interval code compares the given digit group
  function automatic logic uses_code(input logic [3:0] code,
                                     input logic [3:0] first);
    return (code >= first) && (code <= rtc_alarm_pkg::MASK_YEAR);
  endfunction : uses_code

  // Write strobe for one register; every writable register shares this decode
  function automatic logic write_hits(input logic       take,
                                      input logic [4:0] addr,
                                      input logic [4:0] target);
    return take && (addr == target);
  endfunction : write_hits

  // A request is taken on the edge where waitrequest is seen low
  assign bus_req  = read | write;
  assign bus_take = bus_req & ~waitrequest;
  assign wr_take  = write & ~waitrequest;

  // Slave answers one cycle after the request appears, then re-arms
  always_ff @(posedge clk) begin
    if (srst) begin
      waitrequest <= 1'b1;
    end else if (bus_req && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    next_readdata = rtc_alarm_pkg::READ_ZERO;
    case (address)
      rtc_alarm_pkg::ADDR_ALARM_WEEKDAY_DIGIT_HOURS: begin
        next_readdata[15:0] = alarm_weekday_hours & rtc_alarm_pkg::WEEKDAY_DIGIT_HOURS_MASK;
      end
      rtc_alarm_pkg::ADDR_ALARM_MIN_SEC: begin
        next_readdata[15:0] = alarm_minutes_seconds & rtc_alarm_pkg::MIN_SEC_MASK;
      end
      rtc_alarm_pkg::ADDR_ALARM_CONFIG: begin
        next_readdata[rtc_alarm_pkg::CFG_ON_BIT]    = alarm_on;
        next_readdata[rtc_alarm_pkg::CFG_CHIME_BIT] = chime;
        next_readdata[rtc_alarm_pkg::CFG_MASK_MSB:rtc_alarm_pkg::CFG_MASK_LSB] =
          alarm_interval_select;
        next_readdata[rtc_alarm_pkg::CFG_RPT_MSB:rtc_alarm_pkg::CFG_RPT_LSB] = repeat_count;
      end
      rtc_alarm_pkg::ADDR_CLOCK_TRIM: begin
        next_readdata[rtc_alarm_pkg::TRIM_MSB:rtc_alarm_pkg::TRIM_LSB] = trim;
        next_readdata[rtc_alarm_pkg::SYNC_FLAG_BIT] = rollover_pending_flag;
        next_readdata[rtc_alarm_pkg::WR_UNLOCK_BIT] = clock_write_unlock;
      end
      rtc_alarm_pkg::ADDR_STATUS: begin
        next_readdata[rtc_alarm_pkg::STAT_PULSE_BIT] = alarm_pulse;
        next_readdata[rtc_alarm_pkg::STAT_ADJ_BIT]   = (adjust_left != 10'h000);
        next_readdata[rtc_alarm_pkg::STAT_MATCH_BIT] = prev_match;
      end
      default: begin
        next_readdata = rtc_alarm_pkg::READ_ZERO;
      end
    endcase
  end

  // Read data is captured as waitrequest drops and held until the next answer
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata <= rtc_alarm_pkg::READ_ZERO;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Alarm weekday/hours value; writes without unlock are dropped silently
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_weekday_hours <= rtc_alarm_pkg::VALUE_RESET;
    end else if (write_hits(wr_take, address, rtc_alarm_pkg::ADDR_ALARM_WEEKDAY_DIGIT_HOURS) &&
                 clock_write_unlock) begin
      alarm_weekday_hours <= merge_low(alarm_weekday_hours, writedata, byteenable)
                             & rtc_alarm_pkg::WEEKDAY_DIGIT_HOURS_MASK;
    end
  end

  // Alarm minutes/seconds value
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_minutes_seconds <= rtc_alarm_pkg::VALUE_RESET;
    end else if (write_hits(wr_take, address, rtc_alarm_pkg::ADDR_ALARM_MIN_SEC)) begin
      alarm_minutes_seconds <= merge_low(alarm_minutes_seconds, writedata, byteenable)
                               & rtc_alarm_pkg::MIN_SEC_MASK;
    end
  end

  // Trim value and write-unlock bit
  always_ff @(posedge clk) begin
    if (srst) begin
      trim               <= rtc_alarm_pkg::TRIM_RESET;
      clock_write_unlock <= 1'b0;
    end else if (write_hits(wr_take, address, rtc_alarm_pkg::ADDR_CLOCK_TRIM)) begin
      if (byteenable[0]) begin
        trim <= writedata[rtc_alarm_pkg::TRIM_MSB:rtc_alarm_pkg::TRIM_LSB];
      end
      if (byteenable[1]) begin
        clock_write_unlock <= writedata[rtc_alarm_pkg::WR_UNLOCK_BIT];
      end
    end
  end

  // Digit compare for the selected interval; wider codes include narrower digits, except the weekday, compared for the weekly code only
  always_comb begin
    digits_match = 1'b1;
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_TEN_SEC) &&
        now_time.second[rtc_alarm_pkg::SEC_ONES_MSB:0] !=
        alarm_minutes_seconds[rtc_alarm_pkg::SEC_ONES_MSB:rtc_alarm_pkg::SEC_LSB]) begin
      digits_match = 1'b0;
    end
    // Both second digits
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_MINUTE) &&
        now_time.second !=
        alarm_minutes_seconds[rtc_alarm_pkg::SEC_MSB:rtc_alarm_pkg::SEC_LSB]) begin
      digits_match = 1'b0;
    end
    // Minute ones digit
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_TEN_MIN) &&
        now_time.minute[rtc_alarm_pkg::SEC_ONES_MSB:0] !=
        alarm_minutes_seconds[rtc_alarm_pkg::MIN_LSB+rtc_alarm_pkg::SEC_ONES_MSB:
                              rtc_alarm_pkg::MIN_LSB]) begin
      digits_match = 1'b0;
    end
    // Both minute digits
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_HOUR) &&
        now_time.minute !=
        alarm_minutes_seconds[rtc_alarm_pkg::MIN_MSB:rtc_alarm_pkg::MIN_LSB]) begin
      digits_match = 1'b0;
    end
    // Both hour digits
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_DAY) &&
        now_time.hour !=
        alarm_weekday_hours[rtc_alarm_pkg::HOUR_MSB:rtc_alarm_pkg::HOUR_LSB]) begin
      digits_match = 1'b0;
    end
    // Weekday only for the weekly code
    if (alarm_interval_select == rtc_alarm_pkg::MASK_WEEK &&
        now_time.weekday_digit !=
        alarm_weekday_hours[rtc_alarm_pkg::WEEKDAY_DIGIT_MSB:rtc_alarm_pkg::WEEKDAY_DIGIT_LSB]) begin
      digits_match = 1'b0;
    end
    // Day of month, for the monthly and yearly codes
    // Feb 29th only meets in leap years
    if (uses_code(alarm_interval_select, rtc_alarm_pkg::MASK_MONTH) &&
        now_time.day != alarm_month_day.day) begin
      digits_match = 1'b0;
    end
    if (alarm_interval_select == rtc_alarm_pkg::MASK_YEAR &&
        now_time.month != alarm_month_day.month) begin
      digits_match = 1'b0;
    end
  end

  // Match history, sampled on each clock update so equality is seen once
  // It runs while alarms are off too, so enabling never fires on a stale match
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_match <= 1'b0;
    end else if (time_update) begin
      prev_match <= digits_match;
    end
  end

  // Event selection per interval code
  always_comb begin
    alarm_event = 1'b0;
    if (alarm_on) begin
      case (alarm_interval_select)
        rtc_alarm_pkg::MASK_HALF_SEC: begin
          alarm_event = half_sec_tick;
        end
        rtc_alarm_pkg::MASK_SEC: begin
          alarm_event = time_update;
        end
        rtc_alarm_pkg::MASK_TEN_SEC, rtc_alarm_pkg::MASK_MINUTE,
        rtc_alarm_pkg::MASK_TEN_MIN, rtc_alarm_pkg::MASK_HOUR,
        rtc_alarm_pkg::MASK_DAY, rtc_alarm_pkg::MASK_WEEK,
        rtc_alarm_pkg::MASK_MONTH, rtc_alarm_pkg::MASK_YEAR: begin
          alarm_event = time_update & digits_match & ~prev_match;
        end
        // Reserved codes never fire
        default: begin
          alarm_event = 1'b0;
        end
      endcase
    end
  end

  // Configuration; an alarm event in the same cycle as a write wins for enable and count
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_on              <= 1'b0;
      chime                 <= 1'b0;
      alarm_interval_select <= rtc_alarm_pkg::MASK_HALF_SEC;
      repeat_count          <= rtc_alarm_pkg::REPEAT_RESET;
    end else begin
      if (write_hits(wr_take, address, rtc_alarm_pkg::ADDR_ALARM_CONFIG)) begin
        if (byteenable[0]) begin
          repeat_count <= writedata[rtc_alarm_pkg::CFG_RPT_MSB:rtc_alarm_pkg::CFG_RPT_LSB];
        end
        if (byteenable[1]) begin
          alarm_on              <= writedata[rtc_alarm_pkg::CFG_ON_BIT];
          chime                 <= writedata[rtc_alarm_pkg::CFG_CHIME_BIT];
          alarm_interval_select <=
            writedata[rtc_alarm_pkg::CFG_MASK_MSB:rtc_alarm_pkg::CFG_MASK_LSB];
        end
      end
      if (alarm_event) begin
        if (repeat_count != rtc_alarm_pkg::REPEAT_RESET) begin
          repeat_count <= repeat_count - 8'h01;
        end else if (chime) begin
          repeat_count <= rtc_alarm_pkg::REPEAT_WRAP;
        end else begin
          alarm_on <= 1'b0;
        end
      end
    end
  end

  // Alarm request pulse and half-rate pulse output
  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_irq   <= 1'b0;
      alarm_pulse <= 1'b0;
    end else begin
      alarm_irq <= alarm_event;
      if (alarm_event) begin
        alarm_pulse <= ~alarm_pulse;
      end
    end
  end

  // Magnitude of the signed trim; -128 gives 128 so the count fits ten bits
  assign abs_trim = trim[rtc_alarm_pkg::TRIM_MSB] ? (8'h00 - trim) : trim;

  // Pulse budget loaded each minute and spent one pulse per clock
  always_ff @(posedge clk) begin
    if (srst) begin
      adjust_left <= 10'h000;
      adjust_down <= 1'b0;
    // A new minute drops whatever is left of a train still running
    end else if (minute_tick) begin
      adjust_left <= 10'(abs_trim) << rtc_alarm_pkg::TRIM_SHIFT;
      adjust_down <= trim[rtc_alarm_pkg::TRIM_MSB];
    end else if (adjust_left != 10'h000) begin
      adjust_left <= adjust_left - 10'h001;
    end
  end

  // Trim pulses towards the clock counter
  always_ff @(posedge clk) begin
    if (srst) begin
      trim_add_pulse <= 1'b0;
      trim_sub_pulse <= 1'b0;
    end else begin
      trim_sub_pulse <= (adjust_left != 10'h000) & adjust_down & ~minute_tick;
      trim_add_pulse <= (adjust_left != 10'h000) & ~adjust_down & ~minute_tick;
    end
  end

endmodule : rtc_alarm_cal

// File: tb/rtc_alarm_cal_assertions.sv
`timescale 1ns/1ps
// Watches the bus handshake, the alarm outputs and the trim pulse trains
module rtc_alarm_cal_assertions (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        half_sec_tick,
  input wire logic        time_update,
  input wire logic        minute_tick,
  input wire logic        alarm_irq,
  input wire logic        alarm_pulse,
  input wire logic        trim_add_pulse,
  input wire logic        trim_sub_pulse
);
  logic [9:0] run_len;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Length of the running trim train; two merged trains would hide a bad count
  always_ff @(posedge clk) begin
    if (srst) begin
      run_len <= 10'h000;
    end else if (trim_add_pulse || trim_sub_pulse) begin
      run_len <= run_len + 10'h001;
    end else begin
      run_len <= 10'h000;
    end
  end

  // A request waiting, then one answer cycle
  sequence s_req_waiting;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  a_bus_answer: assert property (s_req_waiting |=> s_answer)
    else $error("bus answer not after one wait state");
  a_bus_rest: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("answer without a request");
  a_rdata_hold: assert property ($changed(readdata) |-> !waitrequest && $past(read))
    else $error("read data moved outside a read answer");
  a_irq_cause: assert property (alarm_irq |-> $past(time_update) || $past(half_sec_tick))
    else $error("alarm request without a clock update");
  a_pulse_toggle: assert property (alarm_irq |-> alarm_pulse != $past(alarm_pulse))
    else $error("alarm pulse did not toggle on an event");
  a_pulse_steady: assert property (!alarm_irq |-> $stable(alarm_pulse))
    else $error("alarm pulse moved without an event");
  a_add_start: assert property ($rose(trim_add_pulse) |-> $past(minute_tick, 2))
    else $error("add train not two cycles after minute tick");
  a_sub_start: assert property ($rose(trim_sub_pulse) |-> $past(minute_tick, 2))
    else $error("subtract train not two cycles after minute tick");
  a_trim_excl: assert property (!(trim_add_pulse && trim_sub_pulse))
    else $error("add and subtract pulses together");
  a_trim_quad: assert property ($fell(trim_add_pulse || trim_sub_pulse) |->
    run_len[1:0] == 2'h0 && run_len != 10'h000)
    else $error("trim train not a multiple of four");
endmodule : rtc_alarm_cal_assertions

bind rtc_alarm_cal rtc_alarm_cal_assertions i_rtc_alarm_cal_assertions (
  .clk(clk), .srst(srst), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .half_sec_tick(half_sec_tick), .time_update(time_update),
  .minute_tick(minute_tick), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse),
  .trim_add_pulse(trim_add_pulse), .trim_sub_pulse(trim_sub_pulse)
);

// File: tb/tb_rtc_alarm_cal.sv
`timescale 1ns/1ps
module tb_rtc_alarm_cal;
  localparam logic [4:0] adr_wh   = rtc_alarm_pkg::ADDR_ALARM_WEEKDAY_DIGIT_HOURS;
  localparam logic [4:0] adr_ms   = rtc_alarm_pkg::ADDR_ALARM_MIN_SEC;
  localparam logic [4:0] adr_cfg  = rtc_alarm_pkg::ADDR_ALARM_CONFIG;
  localparam logic [4:0] adr_trim = rtc_alarm_pkg::ADDR_CLOCK_TRIM;
  localparam logic [4:0] hits     = 5'h16;
  localparam logic [4:0] rises    = 5'h12;
  localparam logic [4:0] every    = 5'h03;
  logic                       clk;
  logic                       srst;
  logic [4:0]                 address;
  logic                       read;
  logic                       write;
  logic [31:0]                writedata;
  logic [3:0]                 byteenable;
  logic [31:0]                readdata;
  logic                       waitrequest;
  rtc_alarm_pkg::clock_time_t now_time;
  rtc_alarm_pkg::clock_time_t alm;
  rtc_alarm_pkg::month_day_t  alarm_month_day;
  logic                       half_sec_tick;
  logic                       time_update;
  logic                       minute_tick;
  logic                       rollover_pending_flag;
  logic                       alarm_irq;
  logic                       alarm_pulse;
  logic                       trim_add_pulse;
  logic                       trim_sub_pulse;
  logic                       exp_pulse = 1'h0;
  logic                       run_sub = 1'h0;
  logic [9:0]                 run = 10'h000;
  logic [31:0]                exp_rd[$];
  logic                       exp_al[$];
  logic [10:0]                exp_trim[$];
  logic [31:0]                d;
  int                         fail_count = 0;
  int                         samples_checked = 0;

  rtc_alarm_cal i_rtc_alarm_cal (
    .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .now_time(now_time), .alarm_month_day(alarm_month_day),
    .half_sec_tick(half_sec_tick), .time_update(time_update), .minute_tick(minute_tick),
    .rollover_pending_flag(rollover_pending_flag), .alarm_irq(alarm_irq),
    .alarm_pulse(alarm_pulse), .trim_add_pulse(trim_add_pulse),
    .trim_sub_pulse(trim_sub_pulse)
  );

  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s at %0t: %h vs %h", what, $time, got, exp);
    end
  endtask : check

  // One Avalon transfer; held until waitrequest is seen low, bounded wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] v,
                     input logic [31:0] exp);
    int n;
    @(posedge clk);
    address    <= a;
    write      <= wr;
    read       <= ~wr;
    writedata  <= v;
    byteenable <= 4'hF;
    if (!wr) exp_rd.push_back(exp);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 50);
    read  <= 1'h0;
    write <= 1'h0;
    if (n >= 50) begin
      check(32'h1, 32'h0, "bus timeout");
      close_out();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    bus(1'h1, a, v, 32'h0);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, exp);
  endtask : rd

  // Present a time, then one update or half-second tick; note the event if due
  task automatic upd(input rtc_alarm_pkg::clock_time_t t, input logic ev, input logic half);
    @(posedge clk);
    now_time <= t;
    @(posedge clk);
    time_update   <= ~half;
    half_sec_tick <= half;
    if (ev) begin
      exp_pulse = ~exp_pulse;
      exp_al.push_back(exp_pulse);
    end
    @(posedge clk);
    time_update   <= 1'h0;
    half_sec_tick <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : upd

  // Trim written between minute ticks, then one minute tick and the whole train
  task automatic trim_run(input logic [7:0] t);
    logic [7:0] mag;
    mag = t[7] ? -t : t;
    wr(adr_trim, 32'h0000_2000 | {24'h0, t});
    if (mag != 8'h00) exp_trim.push_back({t[7], mag, 2'h0});
    @(posedge clk);
    minute_tick <= 1'h1;
    @(posedge clk);
    minute_tick <= 1'h0;
    repeat (int'(mag) * 4 + 8) @(posedge clk);
  endtask : trim_run

  function automatic logic [31:0] cfg(input logic on, input logic ch, input int c,
                                      input logic [7:0] r);
    return {16'h0, on, ch, 4'(c), 2'h0, r};
  endfunction : cfg

  // Compared digits equal the alarm, others differ; a miss breaks the top compared digit
  function automatic rtc_alarm_pkg::clock_time_t mk_time(input int c, input logic hit);
    rtc_alarm_pkg::clock_time_t t;
    t.month  = (c == 9) ? alm.month : 5'h03;
    t.day    = (c >= 8) ? alm.day : 6'h05;
    t.weekday_digit   = (c == 7) ? alm.weekday_digit : 3'h5;
    t.hour   = (c >= 6) ? alm.hour : 6'h07;
    t.minute = (c >= 5) ? alm.minute : ((c == 4) ? 7'h24 : 7'h21);
    t.second = (c >= 3) ? alm.second : ((c == 2) ? 7'h46 : 7'h47);
    if (!hit) begin
      case (c)
        2: t.second ^= 7'h01;
        3: t.second ^= 7'h10;
        4: t.minute ^= 7'h01;
        5: t.minute ^= 7'h10;
        6: t.hour ^= 6'h01;
        7: t.weekday_digit ^= 3'h1;
        8: t.day ^= 6'h01;
        default: t.month ^= 5'h01;
      endcase
    end
    return t;
  endfunction : mk_time

  // Take the oldest note whenever the block answers a read, alarms or ends a trim train
  always @(posedge clk) begin
    if (srst === 1'h0) begin
      if (read === 1'h1 && waitrequest === 1'h0) begin
        if (exp_rd.size() == 0) check(32'h1, 32'h0, "read");
        else check(readdata, exp_rd.pop_front(), "read");
      end
      if (alarm_irq !== 1'h0) begin
        if (exp_al.size() == 0) check(32'h1, 32'h0, "alarm");
        else check({31'h0, alarm_pulse}, {31'h0, exp_al.pop_front()}, "alarm");
      end
      if (trim_add_pulse === 1'h1 || trim_sub_pulse === 1'h1) begin
        run = run + 10'h001;
        run_sub = trim_sub_pulse;
      end else if (run != 10'h000) begin
        if (exp_trim.size() == 0) check(32'h1, 32'h0, "trim");
        else check({21'h0, run_sub, run}, {21'h0, exp_trim.pop_front()}, "trim");
        run = 10'h000;
      end
    end
  end

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // Cuts a hang short
  initial begin
    repeat (100000) @(posedge clk);
    check(32'h1, 32'h0, "run timeout");
    close_out();
  end

  initial begin
    {srst, read, write, half_sec_tick, time_update, minute_tick} = 6'h20;
    {rollover_pending_flag, address, writedata, byteenable} = 42'h0;
    now_time = 34'h0;
    alm = {5'h02, 6'h29, 3'h3, 6'h12, 7'h34, 7'h56};
    alarm_month_day = {alm.month, alm.day};
    void'($urandom(71568));
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    // reset values, status and an unmapped place all read zero
    for (int a = 0; a < 6; a++) rd(5'(a * 4), 32'h0);
    // weekday/hours locked until the unlock bit is set
    wr(adr_wh, 32'hFFFF_FFFF);
    rd(adr_wh, 32'h0);
    rollover_pending_flag <= 1'h1;
    wr(adr_trim, 32'h0000_F000);
    rd(adr_trim, 32'h0000_3000);
    rollover_pending_flag <= 1'h0;
    wr(adr_wh, 32'hFFFF_FFFF);
    rd(adr_wh, 32'h0000_073F);
    repeat (3) begin
      d = $urandom();
      wr(adr_ms, d);
      rd(adr_ms, d & 32'h0000_7F7F);
      wr(adr_wh, d);
      rd(adr_wh, d & 32'h0000_073F);
    end
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0);
    // alarm values written while alarms are off
    wr(adr_wh, 32'h0000_0312);
    wr(adr_ms, 32'h0000_3456);
    // interval codes 1 to 9, two alarms each
    for (int c = 1; c < 10; c++) begin
      wr(adr_cfg, cfg(1'h1, 1'h0, c, 8'h01));
      for (int k = 0; k < 5; k++) begin
        upd(mk_time(c, hits[k]), (c == 1) ? every[k] : rises[k], 1'h0);
      end
      rd(adr_cfg, cfg(1'h0, 1'h0, c, 8'h00));
    end
    // half-second code, single alarm then off
    wr(adr_cfg, cfg(1'h1, 1'h0, 0, 8'h00));
    upd(now_time, 1'h1, 1'h1);
    upd(now_time, 1'h0, 1'h1);
    rd(adr_cfg, 32'h0);
    // chime wraps the count and keeps alarming
    wr(adr_cfg, cfg(1'h1, 1'h1, 1, 8'h00));
    repeat (3) upd(now_time, 1'h1, 1'h0);
    rd(adr_cfg, cfg(1'h1, 1'h1, 1, 8'hFD));
    // full count drops by one per alarm
    wr(adr_cfg, cfg(1'h1, 1'h0, 1, 8'hFF));
    upd(now_time, 1'h1, 1'h0);
    rd(adr_cfg, cfg(1'h1, 1'h0, 1, 8'hFE));
    wr(adr_cfg, 32'h0);
    upd(now_time, 1'h0, 1'h0);
    // trim trains of four pulses per unit
    trim_run(8'h03);
    trim_run(8'hFE);
    trim_run(8'h80);
    trim_run(8'h00);
    trim_run(8'($urandom()));
    repeat (10) @(posedge clk);
    check(32'(exp_rd.size() + exp_al.size() + exp_trim.size()), 32'h0, "pending");
    close_out();
  end
endmodule : tb_rtc_alarm_cal
